// file: fast_event_counter_defs.vh
// Constants shared by the fast event counter design files.
`ifndef FAST_EVENT_COUNTER_DEFS_VH
`define FAST_EVENT_COUNTER_DEFS_VH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 32'd40
`define CLK_HZ 32'd25000000
`define FILTER_DEFAULT_US 32'd6400
`define FILTER_DEFAULT_CYC (`FILTER_DEFAULT_US * 32'd1000 / `CLK_PERIOD_NS)
`define PERIOD_10MS_MS 32'd10
`define PERIOD_100MS_MS 32'd100
`define PERIOD_1000MS_MS 32'd1000
`define MS_TO_CYC(ms) ((ms) * (`CLK_HZ / 32'd1000))
`define SCALE_10MS 32'd100
`define SCALE_100MS 32'd10
`define SCALE_1000MS 32'd1

// ----------------------------------------------------------------------------
// Counter types and period selection codes
// ----------------------------------------------------------------------------
`define TYPE_SINGLE_INT 2'h0
`define TYPE_SINGLE_EXT 2'h1
`define TYPE_TWO_CLOCK 2'h2
`define TYPE_QUADRATURE 2'h3
`define SEL_10MS 2'h0
`define SEL_100MS 2'h1
`define SEL_1000MS 2'h2

// ----------------------------------------------------------------------------
// Function selection codes
// ----------------------------------------------------------------------------
`define FUNC_COUNT 2'h0
`define FUNC_FREQ 2'h1
`define FUNC_PERIOD 2'h2

// ----------------------------------------------------------------------------
// Elapsed time limits
// ----------------------------------------------------------------------------
`define SPAN_MAX 32'hfffffff0
`define SPAN_OVERFLOW 32'hffffffff
`define ZERO32 32'h00000000

`endif

// file: input_filter.v
// Digital input filter for one counter input with a settable settle time.
`timescale 1ns/1ps
`default_nettype none
`include "fast_event_counter_defs.vh"

module input_filter (
    input wire mclk,
    input wire resetn,
    input wire raw_in,
    input wire [31:0] settle_cycles,
    output reg clean
);

// ----------------------------------------------------------------------------
// Settle counter
// ----------------------------------------------------------------------------
reg [31:0] stable_count;

// The output follows the input only after it has held a new level long enough.
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        stable_count <= `ZERO32;
        clean <= 1'b0;
    end else if (raw_in == clean) begin
        stable_count <= `ZERO32;
    end else if (stable_count + 32'd1 >= settle_cycles) begin
        clean <= raw_in;
        stable_count <= `ZERO32;
    end else begin
        stable_count <= stable_count + 32'd1;
    end
end

endmodule // input_filter
`default_nettype wire

// file: fast_event_counter.v
// Fast event counter with count, frequency and period measurement functions.
`timescale 1ns/1ps
`default_nettype none
`include "fast_event_counter_defs.vh"

module fast_event_counter (
    input wire mclk,
    input wire resetn,
    input wire input_a,
    input wire input_b,
    input wire reset_input,
    input wire [1:0] counter_type,
    input wire [1:0] function_select,
    input wire reset_enable,
    input wire initial_up,
    input wire [31:0] filter_cycles,
    input wire counter_control_request,
    input wire load_direction,
    input wire load_count,
    input wire load_preset,
    input wire load_period,
    input wire next_direction_up,
    input wire [31:0] next_count_value,
    input wire [31:0] next_preset_value,
    input wire [1:0] next_period_select,
    output reg [31:0] count_value,
    output reg [31:0] preset_value,
    output reg direction_up,
    output reg [1:0] period_select,
    output reg count_below_preset,
    output reg event_equal,
    output reg event_reset,
    output reg event_direction,
    output reg [31:0] frequency_hz,
    output reg frequency_valid,
    output reg [31:0] span_time_ns,
    output reg [31:0] interval_event_total,
    output reg period_valid
);

// ----------------------------------------------------------------------------
// Input filters
// ----------------------------------------------------------------------------
wire a_clean;
wire b_clean;
wire r_clean;

// Each counter input passes its own filter; settle time comes from filter_cycles.
input_filter filter_a (
    .mclk(mclk),
    .resetn(resetn),
    .raw_in(input_a),
    .settle_cycles(filter_cycles),
    .clean(a_clean)
);

input_filter filter_b (
    .mclk(mclk),
    .resetn(resetn),
    .raw_in(input_b),
    .settle_cycles(filter_cycles),
    .clean(b_clean)
);

input_filter filter_r (
    .mclk(mclk),
    .resetn(resetn),
    .raw_in(reset_input),
    .settle_cycles(filter_cycles),
    .clean(r_clean)
);

// ----------------------------------------------------------------------------
// Edge detection
// ----------------------------------------------------------------------------
reg a_prev;
reg b_prev;
reg r_prev;

// Previous filtered levels give the edges of each input.
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        a_prev <= 1'b0;
        b_prev <= 1'b0;
        r_prev <= 1'b0;
    end else begin
        a_prev <= a_clean;
        b_prev <= b_clean;
        r_prev <= r_clean;
    end
end

wire a_rise = a_clean & ~a_prev;
wire b_rise = b_clean & ~b_prev;
wire a_edge = a_clean ^ a_prev;
wire b_edge = b_clean ^ b_prev;

// ----------------------------------------------------------------------------
// Step decode per counter type
// ----------------------------------------------------------------------------
reg step;
reg step_up;

// A quadrature step is an edge on one phase alone; direction follows which phase leads.
always @* begin
    case (counter_type)
        `TYPE_SINGLE_INT: begin
            step = a_rise;
            step_up = direction_up;
        end
        `TYPE_SINGLE_EXT: begin
            step = a_rise;
            step_up = b_clean;
        end
        `TYPE_TWO_CLOCK: begin
            step = a_rise ^ b_rise;
            step_up = a_rise;
        end
        default: begin
            step = a_edge ^ b_edge;
            step_up = a_edge ? (a_clean ^ b_clean) : ~(a_clean ^ b_clean);
        end
    endcase
end

// Reset input acts only when enabled and in counting function; held, it clears.
wire reset_active = reset_enable & r_clean & (function_select == `FUNC_COUNT);
wire reset_rise = reset_active & ~r_prev;

// ----------------------------------------------------------------------------
// Current count, preset and direction
// ----------------------------------------------------------------------------
reg [31:0] next_count;
reg last_step_up;
reg have_step;
reg start_loaded;

// Next count: reset, then control load, then counting steps.
always @* begin
    next_count = count_value;
    if (reset_active) begin
        next_count = `ZERO32;
    end else if (counter_control_request && load_count) begin
        next_count = next_count_value;
    end else if (step && function_select == `FUNC_COUNT) begin
        next_count = step_up ? count_value + 32'd1 : count_value - 32'd1;
    end
end

// Count register, control loads and the three counter events.
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        count_value <= `ZERO32;
        preset_value <= `ZERO32;
        direction_up <= 1'b1;
        period_select <= `SEL_10MS;
        event_equal <= 1'b0;
        event_reset <= 1'b0;
        event_direction <= 1'b0;
        last_step_up <= 1'b1;
        have_step <= 1'b0;
        start_loaded <= 1'b0;
        count_below_preset <= 1'b0;
    end else begin
        count_value <= next_count;
        count_below_preset <= (count_value < preset_value);
        start_loaded <= 1'b1;
        if (counter_control_request && load_preset) begin
            preset_value <= next_preset_value;
        end
        if (!start_loaded) begin
            direction_up <= initial_up;
        end
        if (counter_control_request && load_direction) begin
            direction_up <= next_direction_up;
        end
        if (counter_control_request && load_period) begin
            period_select <= next_period_select;
        end
        event_equal <= (next_count == (counter_control_request && load_preset ?
            next_preset_value : preset_value)) && (next_count != count_value);
        event_reset <= reset_rise;
        event_direction <= 1'b0;
        if (step && function_select == `FUNC_COUNT) begin
            have_step <= 1'b1;
            last_step_up <= step_up;
            event_direction <= have_step && (step_up != last_step_up);
        end
    end
end

// ----------------------------------------------------------------------------
// Measurement interval timer
// ----------------------------------------------------------------------------
reg [31:0] interval_cycles;
reg [31:0] freq_scale;
reg [31:0] interval_timer;

// Interval length and hertz scale for the selected period.
always @* begin
    case (period_select)
        `SEL_100MS: begin
            interval_cycles = `MS_TO_CYC(`PERIOD_100MS_MS);
            freq_scale = `SCALE_100MS;
        end
        `SEL_1000MS: begin
            interval_cycles = `MS_TO_CYC(`PERIOD_1000MS_MS);
            freq_scale = `SCALE_1000MS;
        end
        default: begin
            interval_cycles = `MS_TO_CYC(`PERIOD_10MS_MS);
            freq_scale = `SCALE_10MS;
        end
    endcase
end

wire interval_end = (interval_timer + 32'd1 >= interval_cycles);

// Free-running interval timer restarts at each interval end.
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        interval_timer <= `ZERO32;
    end else if (interval_end) begin
        interval_timer <= `ZERO32;
    end else begin
        interval_timer <= interval_timer + 32'd1;
    end
end

// ----------------------------------------------------------------------------
// Frequency and period measurement
// ----------------------------------------------------------------------------
reg [31:0] edge_total;
reg [31:0] first_stamp;
reg [31:0] last_stamp;
reg [31:0] time_ns;
reg time_wrapped;
reg any_event;

wire [31:0] time_next = time_ns + `CLK_PERIOD_NS;
wire [31:0] span_in = last_stamp - first_stamp;
wire [31:0] span_idle = time_ns - last_stamp;

// Saturate a span: overflow code or clamp out of the reserved band.
function [31:0] clamp_span;
    input [31:0] raw;
    input wrapped;
    begin
        clamp_span = wrapped ? `SPAN_OVERFLOW : ((raw > `SPAN_MAX) ? `SPAN_MAX : raw);
    end
endfunction

// Counts events per interval and publishes frequency or period records.
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        edge_total <= `ZERO32;
        first_stamp <= `ZERO32;
        last_stamp <= `ZERO32;
        time_ns <= `ZERO32;
        time_wrapped <= 1'b0;
        any_event <= 1'b0;
        frequency_hz <= `ZERO32;
        frequency_valid <= 1'b0;
        span_time_ns <= `ZERO32;
        interval_event_total <= `ZERO32;
        period_valid <= 1'b0;
    end else begin
        frequency_valid <= 1'b0;
        period_valid <= 1'b0;
        time_ns <= time_next[31:0];
        if (any_event && span_idle > `SPAN_MAX - `CLK_PERIOD_NS) begin
            time_wrapped <= 1'b1;
        end
        if (step) begin
            if (edge_total == `ZERO32) begin
                first_stamp <= time_ns;
            end
            last_stamp <= time_ns;
            any_event <= 1'b1;
        end
        if (interval_end) begin
            if (function_select == `FUNC_FREQ) begin
                frequency_hz <= edge_total * freq_scale;
                frequency_valid <= 1'b1;
            end
            if (function_select == `FUNC_PERIOD) begin
                interval_event_total <= edge_total;
                if (edge_total != `ZERO32) begin
                    span_time_ns <= clamp_span(span_in, 1'b0);
                end else if (any_event) begin
                    span_time_ns <= clamp_span(span_idle, time_wrapped);
                end else begin
                    span_time_ns <= `SPAN_OVERFLOW;
                end
                period_valid <= 1'b1;
            end
            edge_total <= step ? 32'd1 : `ZERO32;
            if (step) begin
                first_stamp <= time_ns;
            end
            if (edge_total != `ZERO32 || step) begin
                time_wrapped <= 1'b0;
            end
        end else if (step) begin
            edge_total <= edge_total + 32'd1;
        end
    end
end

endmodule // fast_event_counter
`default_nettype wire

// file: fast_event_counter_assertions.sv
// Concurrent checks on the fast event counter ports.
`timescale 1ns/1ps
`default_nettype none
module fast_event_counter_assertions (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic reset_input,
    input wire logic reset_enable,
    input wire logic [1:0] function_select,
    input wire logic [31:0] filter_cycles,
    input wire logic counter_control_request,
    input wire logic load_count,
    input wire logic load_preset,
    input wire logic load_period,
    input wire logic [31:0] next_count_value,
    input wire logic [1:0] next_period_select,
    input wire logic [31:0] count_value,
    input wire logic [31:0] preset_value,
    input wire logic [1:0] period_select,
    input wire logic count_below_preset,
    input wire logic event_equal,
    input wire logic [31:0] span_time_ns,
    input wire logic period_valid
);
    // -------------------------------------------------------------------
    // Sequences and checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_held;
        (reset_enable && reset_input && function_select == 2'h0 && filter_cycles < 32'h4) [*8];
    endsequence
    sequence s_quiet;
        function_select == 2'h0 && !reset_input && !(counter_control_request && load_count);
    endsequence
    a_below_track: assert property (count_below_preset == $past(count_value < preset_value))
        else $error("below flag does not follow count and preset");
    a_equal_event: assert property (event_equal |-> count_value == preset_value)
        else $error("equal event without count at preset");
    a_reset_hold: assert property (s_held |-> count_value == 32'h0)
        else $error("count not held at zero during reset");
    a_mode_hold: assert property (function_select != 2'h0 && $past(function_select) != 2'h0
        && !$past(counter_control_request && load_count) |-> $stable(count_value))
        else $error("count moved outside counting function");
    a_load_count: assert property (counter_control_request && load_count && !reset_input
        && function_select == 2'h0 |=> count_value == $past(next_count_value))
        else $error("count load not applied");
    a_keep_preset: assert property (!(counter_control_request && load_preset)
        |=> $stable(preset_value))
        else $error("preset changed without request");
    a_load_period: assert property (counter_control_request && load_period
        |=> period_select == $past(next_period_select))
        else $error("period load not applied");
    a_span_band: assert property (!(span_time_ns inside {[32'hfffffff1:32'hfffffffe]}))
        else $error("span in reserved band");
    a_step_unit: assert property (s_quiet ##1 $changed(count_value) |->
        (count_value - $past(count_value) == 32'h1 || $past(count_value) - count_value == 32'h1))
        else $error("count stepped by more than one");
    a_period_mode: assert property (period_valid |-> function_select == 2'h2)
        else $error("period result outside period function");
endmodule // fast_event_counter_assertions

bind fast_event_counter fast_event_counter_assertions i_fast_event_counter_assertions (
    .mclk, .resetn, .reset_input, .reset_enable, .function_select, .filter_cycles,
    .counter_control_request, .load_count, .load_preset, .load_period, .next_count_value,
    .next_period_select, .count_value, .preset_value, .period_select, .count_below_preset,
    .event_equal, .span_time_ns, .period_valid);
`default_nettype wire

// file: pulse_source.sv
// Pulse source model standing in for a shaft encoder.
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
    input wire logic mclk,
    output logic pa,
    output logic pb
);
    // Both lines rest low; each input has its own line only.
    initial begin
        pa = 1'b0;
        pb = 1'b0;
    end
    // Waits long enough for a level to pass the filter.
    task automatic hold();
        repeat (4) @(posedge mclk);
    endtask
    // One high pulse on A or B, w cycles wide.
    task automatic pulse(input logic ch, input integer w);
        @(posedge mclk);
        if (ch) pb <= 1'b1; else pa <= 1'b1;
        repeat (w) @(posedge mclk);
        if (ch) pb <= 1'b0; else pa <= 1'b0;
        hold();
    endtask
    // Sets the B level, used as external direction.
    task automatic level_b(input logic v);
        @(posedge mclk);
        pb <= v;
        hold();
    endtask
    // One full quadrature cycle; A leads B when up.
    task automatic quad(input logic up);
        integer k;
        for (k = 0; k < 4; k++) begin
            @(posedge mclk);
            if (up ^ k[0]) pa <= ~pa; else pb <= ~pb;
            hold();
        end
    endtask
endmodule // pulse_source
`default_nettype wire

// file: high_speed_event_counter_bench.sv
// Self-checking bench for the fast event counter.
`timescale 1ns/1ps
`default_nettype none
`include "fast_event_counter_defs.vh"
module high_speed_event_counter_bench;
    // -------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------
    reg mclk = 1'b0;
    reg resetn = 1'b0;
    reg rst_in = 1'b0;
    reg rst_en = 1'b0;
    reg req = 1'b0;
    reg [3:0] flags = 4'h0;
    reg nd = 1'b0;
    reg [1:0] ctype = 2'h0;
    reg [1:0] fsel = 2'h0;
    reg [1:0] nps = 2'h0;
    reg [31:0] ncv = 32'h0;
    reg [31:0] npv = 32'h0;
    reg [31:0] filt = 32'h2;
    reg [31:0] seed = 32'h000023ab;
    reg [31:0] ecv = 32'h0;
    reg [31:0] epv = 32'h0;
    reg [31:0] cycles = 32'h0;
    reg [31:0] r;
    reg edir = 1'b1;
    reg [1:0] eps = 2'h0;
    reg ini = 1'b1;
    reg moved = 1'b0;
    reg lup = 1'b1;
    integer xeq = 0;
    integer xdir = 0;
    integer n_eq = 0;
    integer n_rst = 0;
    integer n_dir = 0;
    integer num_errors = 0;
    integer total_checks = 0;
    integer i;
    wire pa, pb, dir, below, ev_eq, ev_rst, ev_dir;
    wire [31:0] cv, pv, span;
    wire [1:0] ps;
    pulse_source i_pulse_source (.mclk(mclk), .pa(pa), .pb(pb));
    fast_event_counter i_fast_event_counter (.mclk(mclk), .resetn(resetn), .input_a(pa),
        .input_b(pb), .reset_input(rst_in), .counter_type(ctype), .function_select(fsel),
        .reset_enable(rst_en), .initial_up(ini), .filter_cycles(filt),
        .counter_control_request(req), .load_direction(flags[0]), .load_count(flags[1]),
        .load_preset(flags[2]), .load_period(flags[3]), .next_direction_up(nd),
        .next_count_value(ncv), .next_preset_value(npv), .next_period_select(nps),
        .count_value(cv), .preset_value(pv), .direction_up(dir), .period_select(ps),
        .count_below_preset(below), .event_equal(ev_eq), .event_reset(ev_rst),
        .event_direction(ev_dir),
        .frequency_hz(), .frequency_valid(), .span_time_ns(span), .interval_event_total(),
        .period_valid());
    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] stepped(input logic [31:0] c, input logic up,
        input logic [31:0] n);
        return up ? c + n : c - n;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input integer n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // One control request; f bits are direction, count, preset, period.
    task automatic load(input logic [3:0] f, input logic [31:0] d, input logic [31:0] c,
        input logic [31:0] p, input logic [31:0] t);
        @(posedge mclk);
        req <= 1'b1;
        flags <= f;
        nd <= d[0];
        ncv <= c;
        npv <= p;
        nps <= t[1:0];
        @(posedge mclk);
        req <= 1'b0;
        flags <= 4'h0;
        if (f[0]) edir = d[0];
        if (f[1]) ecv = c;
        if (f[2]) epv = p;
        if (f[3]) eps = t[1:0];
        cyc(2);
        check(cv, ecv);
        check(pv, epv);
        check({31'h0, dir}, {31'h0, edir});
        check({30'h0, ps}, {30'h0, eps});
    endtask
    // Kind 0 A pulse, 1 B pulse, 2 quadrature cycle, 3 short A glitch.
    task automatic step(input integer kind, input logic up, input logic [31:0] n);
        integer k;
        case (kind)
            0: i_pulse_source.pulse(1'b0, 4);
            1: i_pulse_source.pulse(1'b1, 4);
            2: i_pulse_source.quad(up);
            default: i_pulse_source.pulse(1'b0, 1);
        endcase
        cyc(6);
        for (k = 1; k <= n; k++) begin
            if (stepped(ecv, up, k) == epv) xeq = xeq + 1;
        end
        if (kind != 3 && fsel == `FUNC_COUNT) begin
            if (moved && up != lup) xdir = xdir + 1;
            moved = 1'b1;
            lup = up;
        end
        ecv = stepped(ecv, up, n);
        check(cv, ecv);
        check({31'h0, below}, {31'h0, ecv < epv});
        check(n_eq, xeq);
        check(n_dir, xdir);
    endtask
    // -------------------------------------------------------------------
    // Clock, timeout and main sequence
    // -------------------------------------------------------------------
    initial forever #20 mclk = ~mclk;
    // Counts the one-cycle event pulses for later comparison.
    always @(posedge mclk) begin
        n_eq <= n_eq + ev_eq;
        n_rst <= n_rst + ev_rst;
        n_dir <= n_dir + ev_dir;
    end
    // Cuts a hang short.
    always @(posedge mclk) begin
        cycles <= cycles + 32'h1;
        if (cycles == 32'd20000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    initial begin
        r = rnd();
        edir = r[0];
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        ini <= r[0];
        cyc(2);
        check(cv, 32'h0);
        check(pv, 32'h0);
        check({31'h0, dir}, {31'h0, edir});
        check({30'h0, ps}, 32'h0);
        for (i = 0; i < 16; i++) begin
            load(i[3:0], rnd(), rnd(), rnd(), rnd() % 32'h3);
        end
        r = rnd();
        load(4'h7, 32'h1, r, r + 32'h2, 32'h0);
        step(0, 1'b1, 32'h1);
        step(0, 1'b1, 32'h1);
        load(4'h1, 32'h0, 32'h0, 32'h0, 32'h0);
        step(0, 1'b0, 32'h1);
        @(posedge mclk) filt <= 32'h8;
        step(3, 1'b1, 32'h0);
        @(posedge mclk) filt <= 32'h2;
        @(posedge mclk) ctype <= `TYPE_SINGLE_EXT;
        step(0, 1'b0, 32'h1);
        i_pulse_source.level_b(1'b1);
        step(0, 1'b1, 32'h1);
        i_pulse_source.level_b(1'b0);
        @(posedge mclk) ctype <= `TYPE_TWO_CLOCK;
        step(0, 1'b1, 32'h1);
        step(1, 1'b0, 32'h1);
        @(posedge mclk) ctype <= `TYPE_QUADRATURE;
        step(2, 1'b1, 32'h4);
        step(2, 1'b0, 32'h4);
        check({31'h0, dir}, 32'h0);
        for (i = 0; i < 4; i++) begin
            r = rnd();
            step(2, r[0], 32'h4);
        end
        @(posedge mclk) rst_en <= 1'b1;
        rst_in <= 1'b1;
        cyc(6);
        ecv = 32'h0;
        step(2, 1'b1, 32'h0);
        @(posedge mclk) rst_in <= 1'b0;
        cyc(6);
        step(2, 1'b1, 32'h4);
        @(posedge mclk) fsel <= `FUNC_PERIOD;
        rst_in <= 1'b1;
        step(2, 1'b1, 32'h0);
        @(posedge mclk) rst_in <= 1'b0;
        cyc(6);
        check(cv, ecv);
        check(n_rst, 32'h1);
        conclude();
    end
endmodule // high_speed_event_counter_bench
`default_nettype wire
